// ### logic/fps_front_panel_ctrl.sv
// Front panel settings, oscillator trim and general purpose outputs.
//
// The register offsets and the strobed register port are this design's own decisions.
`include "fps_defs.svh"
// Overview of operation
// - Up and down held at power-on restores defaults.
// - Default restore keeps the oscillator trim.
// - Firmware update leaves the trim untouched.
// - On the video item, up held plus reference press enters trim.
// - Signed trim clamped to plus minus 999.
// - Each trim step is 1/64 sample period.
// - Set stores trim, display returns to time code.
// - Set reshows item; down leaves it.
// - Two logic outputs and four relay outputs.
// - Third relay follows first aux fader.
// - Fourth relay follows second aux fader.
// - Defaults: zero start, eight frames, gain -1.
// - Legacy synchronizer emulation on or off.
// - Two video inputs, reference and overlay.
module fps_front_panel_ctrl
   import fps_pkg::*;
#(
   parameter int DEBOUNCE_CYC = `FPS_DEBOUNCE_CYC
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [3:0] sw_raw,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic [2:0] menu_state,
   output logic defaults_restored_msg,
   output logic signed [15:0] trim_out,
   output logic signed [21:0] trim_phase_out,
   output logic [1:0] ttl_out,
   output logic [3:0] relay_out,
   output logic legacy_sync_emulation,
   output logic ref_video_sel,
   output logic overlay_video_sel,
   output logic [31:0] gen_start_out,
   output logic [7:0] freewheel_out,
   output logic signed [3:0] servo_gain_out
);
   // Debounced switch events travel through the carrier interface.
   fps_keys_if kif ();
   fps_keys_t k;
   assign k = kif.keys;

   // Switch debouncer instance.
   fps_switch_debounce #(
      .DEBOUNCE_CYC(DEBOUNCE_CYC)
   ) u_deb (
      .clock(clock),
      .reset(reset),
      .sw_raw(sw_raw),
      .kif(kif)
   );

   // Menu state and its next value.
   fps_menu_t menu_q;
   fps_menu_t menu_d;
   // Trim being edited, and the stored copy which no reset touches.
   logic signed [15:0] edit_q;
   // Blank-part state of the stored trim; only a store writes it later.
   logic signed [15:0] trim_store_q = `FPS_DEF_TRIM;
   // Set by the first store, so the shown trim leaves its blank value.
   logic trim_valid_q = 1'b0;
   // Resettable settings.
   logic legacy_q;
   logic vidref_q;
   logic fwupd_q;
   logic [31:0] gen_start_q;
   logic [7:0] freewheel_q;
   logic signed [3:0] servo_q;
   logic [1:0] ttl_q;
   logic [3:0] relay_q;
   // Power-on window: catches both switches held at first settle.
   logic [31:0] por_cnt_q;
   logic por_done_q;
   logic restore_q;
   // Trim item comes back on the next set after a store, until down.
   logic reshow_q;

   // Saturating trim step shared by up and down.
   function automatic logic signed [15:0] trim_step(
      input logic signed [15:0] v,
      input logic up
   );
      logic signed [15:0] r;
      r = v;
      if (up && v < `FPS_TRIM_MAX) begin
         r = v + 16'sd1;
      end else if (!up && v > `FPS_TRIM_MIN) begin
         r = v - 16'sd1;
      end
      return r;
   endfunction : trim_step

   // Decoded register writes and reads.
   wire wr_ctrl = reg_wr && (reg_addr == `FPS_REG_CTRL);
   wire wr_gpo = reg_wr && (reg_addr == `FPS_REG_GPO);
   wire wr_set = reg_wr && (reg_addr == `FPS_REG_SETTINGS);
   wire wr_fader = reg_wr && (reg_addr == `FPS_REG_FADER);
   // Power-on window closes once the debouncer has had time to settle.
   wire por_end = !por_done_q &&
      (por_cnt_q >= 32'(2 * DEBOUNCE_CYC + 4));
   wire restore_now = por_end && k.up_lvl && k.down_lvl;
   // A set while the value is shown stores it and arms the reshow.
   wire store_now = (menu_q == FPS_SHOW_TRIM_VAL) && k.set_press;
   // A down while the item is shown drops the shortcut back to it.
   wire leave_now = (menu_q == FPS_SHOW_TRIM_ITEM) && k.down_press;

   // Menu walk: video item, hidden entry, trim edit and exit.
   always_comb begin
      menu_d = menu_q;
      unique case (menu_q)
         FPS_SHOW_TC: begin
            // set reshows the item only while armed
            if (k.set_press) begin
               menu_d = reshow_q ? FPS_SHOW_TRIM_ITEM : FPS_SHOW_VIDEO;
            end
         end
         FPS_SHOW_VIDEO: begin
            if (k.up_lvl && k.ref_press) begin
               menu_d = FPS_SHOW_TRIM_ITEM;
            end else if (k.set_press) begin
               menu_d = FPS_SHOW_TC;
            end
         end
         FPS_SHOW_TRIM_ITEM: begin
            if (k.set_press) begin
               menu_d = FPS_SHOW_TRIM_VAL;
            end else if (k.down_press) begin
               menu_d = FPS_SHOW_TC;
            end
         end
         FPS_SHOW_TRIM_VAL: begin
            if (k.set_press) begin
               menu_d = FPS_SHOW_TC;
            end
         end
         FPS_SHOW_DEFAULTS: begin
            // Set dismisses the defaults message.
            if (k.set_press) begin
               menu_d = FPS_SHOW_TC;
            end
         end
         default: begin
            // Any other code is illegal; fall back to time code.
            menu_d = FPS_SHOW_TC;
         end
      endcase
      if (restore_now) begin
         menu_d = FPS_SHOW_DEFAULTS;
      end
   end

   // Menu register and power-on window.
   always_ff @(posedge clock) begin
      if (reset) begin
         menu_q <= FPS_SHOW_TC;
         por_cnt_q <= 32'h0000_0000;
         por_done_q <= 1'b0;
         restore_q <= 1'b0;
         reshow_q <= 1'b0;
      end else begin
         menu_q <= menu_d;
         // Restore seen stays set until the next reset.
         if (restore_now) begin
            restore_q <= 1'b1;
         end
         // reshow armed by a store, dropped by down
         if (store_now) begin
            reshow_q <= 1'b1;
         end else if (leave_now) begin
            reshow_q <= 1'b0;
         end
         if (!por_done_q) begin
            por_cnt_q <= por_cnt_q + 32'h0000_0001;
         end
         if (por_end) begin
            por_done_q <= 1'b1;
         end
      end
   end

   // firmware update flag does not touch it
   always_ff @(posedge clock) begin
      if (store_now) begin
         trim_store_q <= edit_q;
         trim_valid_q <= 1'b1;
      end
   end

   // Edit copy loads from the store when the value is shown.
   always_ff @(posedge clock) begin
      if (reset) begin
         edit_q <= `FPS_DEF_TRIM;
      end else if (menu_q == FPS_SHOW_TRIM_ITEM && k.set_press) begin
         edit_q <= trim_valid_q ? trim_store_q : `FPS_DEF_TRIM;
      end else if (menu_q == FPS_SHOW_TRIM_VAL) begin
         if (k.up_press) begin
            edit_q <= trim_step(edit_q, 1'b1);
         end else if (k.down_press) begin
            edit_q <= trim_step(edit_q, 1'b0);
         end
      end
   end

   // Resettable settings, restored on power-on with both switches held.
   always_ff @(posedge clock) begin
      if (reset || restore_now) begin
         gen_start_q <= `FPS_DEF_GEN_START;
         freewheel_q <= `FPS_DEF_FREEWHEEL;
         servo_q <= `FPS_DEF_SERVO;
         legacy_q <= `FPS_DEF_LEGACY;
         vidref_q <= 1'b0;
         fwupd_q <= 1'b0;
         ttl_q <= 2'b00;
         relay_q <= 4'h0;
      end else begin
         if (wr_ctrl) begin
            legacy_q <= reg_wdata[`FPS_CTRL_LEGACY];
            vidref_q <= reg_wdata[`FPS_CTRL_VIDREF];
            fwupd_q <= reg_wdata[`FPS_CTRL_FWUPD];
         end
         if (wr_set) begin
            freewheel_q <= reg_wdata[7:0];
            servo_q <= reg_wdata[11:8];
         end
         if (wr_gpo) begin
            ttl_q <= reg_wdata[1:0];
            relay_q[1:0] <= reg_wdata[5:4];
         end
         if (wr_fader) begin
            relay_q[3:2] <= reg_wdata[1:0];
         end
      end
   end

   // Read mux for the register port.
   wire [31:0] rd_mux =
      (reg_addr == `FPS_REG_CTRL) ? {29'h0, fwupd_q, vidref_q, legacy_q} :
      (reg_addr == `FPS_REG_STATUS) ?
         {27'h0, trim_valid_q, restore_q, menu_q} :
      (reg_addr == `FPS_REG_TRIM) ?
         {{16{trim_out[15]}}, trim_out} :
      (reg_addr == `FPS_REG_GPO) ? {26'h0, relay_q, ttl_q} :
      (reg_addr == `FPS_REG_SETTINGS) ?
         {20'h0, servo_q, freewheel_q} : 32'h0000_0000;

   // Registered outputs.
   always_ff @(posedge clock) begin
      if (reset) begin
         reg_rdata <= 32'h0000_0000;
         menu_state <= 3'b000;
         defaults_restored_msg <= 1'b0;
         trim_out <= 16'sd0;
         trim_phase_out <= 22'sd0;
         ttl_out <= 2'b00;
         relay_out <= 4'h0;
         legacy_sync_emulation <= 1'b0;
         ref_video_sel <= 1'b0;
         overlay_video_sel <= 1'b1;
         gen_start_out <= 32'h0000_0000;
         freewheel_out <= 8'h00;
         servo_gain_out <= 4'sd0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
         menu_state <= menu_q;
         defaults_restored_msg <= (menu_q == FPS_SHOW_DEFAULTS);
         trim_out <= trim_valid_q ? trim_store_q : `FPS_DEF_TRIM;
         // one step is 1/64 sample period
         // The output counts 1/4096 periods, so one step moves it by 64.
         trim_phase_out <= 22'(trim_out) * 22'(`FPS_TRIM_STEP_DIV);
         // two logic and four relay outputs
         ttl_out <= ttl_q;
         relay_out <= relay_q;
         legacy_sync_emulation <= legacy_q;
         // one input for reference, other for overlay
         ref_video_sel <= vidref_q;
         overlay_video_sel <= ~vidref_q;
         gen_start_out <= gen_start_q;
         freewheel_out <= freewheel_q;
         servo_gain_out <= servo_q;
      end
   end
endmodule : fps_front_panel_ctrl

// ### logic/fps_defs.svh
// Constants for the front panel setup controller.
`ifndef FPS_DEFS_SVH
`define FPS_DEFS_SVH
// Register offsets.
`define FPS_REG_CTRL 4'h0
`define FPS_REG_STATUS 4'h1
`define FPS_REG_TRIM 4'h2
`define FPS_REG_GPO 4'h3
`define FPS_REG_SETTINGS 4'h4
`define FPS_REG_FADER 4'h5
// Field positions in the control register.
`define FPS_CTRL_LEGACY 0
`define FPS_CTRL_VIDREF 1
`define FPS_CTRL_FWUPD 2
// Trim limits and step size.
`define FPS_TRIM_MAX 16'sd999
`define FPS_TRIM_MIN (-16'sd999)
`define FPS_TRIM_STEP_DIV 64
// Reset values of settings.
`define FPS_DEF_GEN_START 32'h0000_0000
`define FPS_DEF_FREEWHEEL 8'h08
`define FPS_DEF_SERVO (-4'sd1)
`define FPS_DEF_LEGACY 1'b0
`define FPS_DEF_TRIM 16'h0000
// Debounce time and its cycle count at 40 MHz.
`define FPS_CLK_HZ 40000000
`define FPS_DEBOUNCE_US 1000
`define FPS_DEBOUNCE_CYC ((`FPS_CLK_HZ / 1000000) * `FPS_DEBOUNCE_US)
`endif

// ### logic/fps_pkg.sv
// Types for the front panel setup controller.
package fps_pkg;
   // Menu display state.
   typedef enum logic [2:0] {
      FPS_SHOW_TC = 3'b000,
      FPS_SHOW_VIDEO = 3'b001,
      FPS_SHOW_TRIM_ITEM = 3'b010,
      FPS_SHOW_TRIM_VAL = 3'b011,
      FPS_SHOW_DEFAULTS = 3'b100
   } fps_menu_t;
   // Switch events after debouncing.
   typedef struct packed {
      logic up_lvl;
      logic down_lvl;
      logic up_press;
      logic down_press;
      logic set_press;
      logic ref_press;
   } fps_keys_t;
endpackage : fps_pkg

// ### logic/fps_keys_if.sv
// Interface carrying debounced front panel switch events.
interface fps_keys_if;
   fps_pkg::fps_keys_t keys;
   modport src (output keys);
   modport dst (input keys);
endinterface : fps_keys_if

// ### logic/fps_switch_debounce.sv
// Debouncer for the four front panel switches.
`include "fps_defs.svh"
module fps_switch_debounce
   import fps_pkg::*;
#(
   parameter int DEBOUNCE_CYC = `FPS_DEBOUNCE_CYC
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [3:0] sw_raw,
   fps_keys_if.src kif
);
   // Two-stage synchroniser; stage one is only read by stage two.
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   // Stable level and the previous stable level.
   logic [3:0] stable_q;
   logic [3:0] prev_q;
   // Stability counter shared by all switches.
   logic [31:0] cnt_q;
   wire changed = (sync2_q != stable_q);
   wire settled = (cnt_q >= 32'(DEBOUNCE_CYC - 1));

   // Synchroniser for the raw switch levels.
   always_ff @(posedge clock) begin
      sync2_q <= sync1_q;
      sync1_q <= sw_raw;
   end

   // Accept a new level once it has held for the debounce time.
   always_ff @(posedge clock) begin
      if (reset) begin
         cnt_q <= 32'h0000_0000;
         stable_q <= 4'h0;
         prev_q <= 4'h0;
      end else begin
         prev_q <= stable_q;
         if (!changed) begin
            cnt_q <= 32'h0000_0000;
         end else if (settled) begin
            cnt_q <= 32'h0000_0000;
            stable_q <= sync2_q;
         end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
         end
      end
   end

   // Bit order is up, down, set, clock reference.
   wire [3:0] rise = stable_q & ~prev_q;
   // One driver for the whole event word, fields in declaration order.
   assign kif.keys = {stable_q[0], stable_q[1], rise[0], rise[1], rise[2],
      rise[3]};
endmodule : fps_switch_debounce

// ### tb/fps_ctrl_properties.sv
// Checker module and bind for the front panel setup controller.
module fps_ctrl_properties
   import fps_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic [2:0] menu_state,
   input wire logic defaults_restored_msg,
   input wire logic signed [15:0] trim_out,
   input wire logic signed [21:0] trim_phase_out,
   input wire logic [3:0] relay_out,
   input wire logic legacy_sync_emulation,
   input wire logic ref_video_sel,
   input wire logic overlay_video_sel
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   chk_trim_range: assert property (
      trim_out <= 16'sd999 && trim_out >= -16'sd999) else $error("trim out");
   chk_phase_scale: assert property (
      trim_phase_out == {$past(trim_out), 6'h0}) else $error("phase scale");
   chk_msg_menu: assert property (
      defaults_restored_msg == (menu_state == 3'h4)) else $error("msg menu");
   chk_restore_trim: assert property (
      $rose(defaults_restored_msg) |-> $stable(trim_out)) else $error("trim");
   chk_fwupd_trim: assert property (
      reg_wr && reg_addr == 4'h0 |=> $stable(trim_out)) else $error("fw trim");
   chk_trim_entry: assert property (
      menu_state == 3'h2 && $past(menu_state) != 3'h2 |->
      $past(menu_state) inside {3'h0, 3'h1}) else $error("trim entry");
   chk_store_return: assert property (
      $past(menu_state) == 3'h3 && menu_state != 3'h3 |-> menu_state == 3'h0)
      else $error("store return");
   chk_fader_relays: assert property (
      reg_wr && reg_addr == 4'h5 |-> ##2
      relay_out[3:2] == $past(reg_wdata[1:0], 2))
      else $error("fader relays");
   chk_legacy_ctrl: assert property (
      reg_wr && reg_addr == 4'h0 |-> ##2
      legacy_sync_emulation == $past(reg_wdata[0], 2))
      else $error("legacy ctrl");
   chk_video_pair: assert property (
      overlay_video_sel != ref_video_sel) else $error("video pair");
endmodule : fps_ctrl_properties
bind fps_front_panel_ctrl fps_ctrl_properties chk (.clock, .reset, .reg_addr,
   .reg_wdata, .reg_wr, .menu_state, .defaults_restored_msg, .trim_out,
   .trim_phase_out, .relay_out, .legacy_sync_emulation, .ref_video_sel,
   .overlay_video_sel);

// ### tb/fps_operator_model.sv
// Operator model that works the raw front panel switches.
module fps_operator_model (
   input wire logic clock,
   output logic [3:0] sw_raw
);
   timeunit 1ns;
   timeprecision 1ps;
   // Holds a switch pattern for a number of clock cycles.
   task automatic hold(input logic [3:0] m, input int n);
      sw_raw <= m;
      repeat (n) @(posedge clock);
   endtask : hold
   // A momentary press on top of switches already held.
   task automatic tap(input logic [3:0] base, input logic [3:0] m);
      hold(base | m, 10);
      hold(base, 10);
   endtask : tap
endmodule : fps_operator_model

// ### tb/front_panel_setup_ctrl_bench.sv
// Self-checking bench for the front panel setup controller.
module front_panel_setup_ctrl_bench;
   import fps_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [3:0] sw_raw, reg_addr, relay_out;
   logic [31:0] reg_wdata, reg_rdata, gen_start_out, d, v;
   logic reg_wr, reg_rd, defaults_restored_msg, legacy_sync_emulation;
   logic ref_video_sel, overlay_video_sel;
   logic [2:0] menu_state;
   logic signed [15:0] trim_out;
   logic signed [21:0] trim_phase_out;
   logic [1:0] ttl_out;
   logic [7:0] freewheel_out;
   logic signed [3:0] servo_gain_out;
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;
   int trim_m;
   always #12.5 clock = ~clock;
   fps_operator_model op (.clock, .sw_raw);
   fps_front_panel_ctrl #(.DEBOUNCE_CYC(4)) dut (.clock, .reset, .sw_raw,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .menu_state,
      .defaults_restored_msg, .trim_out, .trim_phase_out, .ttl_out, .relay_out,
      .legacy_sync_emulation, .ref_video_sel, .overlay_video_sel,
      .gen_start_out, .freewheel_out, .servo_gain_out);
   // Compares one value against the model and counts the result.
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic conclude;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : conclude
   task automatic wr(input logic [3:0] a, input logic [31:0] x);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= x;
      @(posedge clock);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   // Power cycle with up and down held; the trim must come back intact.
   task automatic power_on(input int t);
      reset <= 1'b1;
      op.hold(4'h3, 3);
      reset <= 1'b0;
      op.hold(4'h3, 30);
      chk("menu", 32'h4, menu_state);
      chk("msg", 32'h1, defaults_restored_msg);
      chk("freewheel", 32'h8, freewheel_out);
      chk("servo", 32'hffff_ffff, servo_gain_out);
      chk("gen_start", 32'h0, gen_start_out);
      chk("trim", t, trim_out);
      op.hold(4'h0, 20);
      $display("power on test done");
   endtask : power_on
   // A runaway run is cut short and counted as a mismatch.
   always @(posedge clock) begin
      cycles++;
      if (cycles > 40000) begin
         failures++;
         conclude();
      end
   end
   initial begin
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      v = $urandom(32'hbd60d942);
      power_on(0);
      op.tap(4'h0, 4'h4);
      op.tap(4'h0, 4'h4);
      chk("video item", 32'h1, menu_state);
      op.hold(4'h1, 12);
      // up held with a reference tap
      op.tap(4'h1, 4'h8);
      op.hold(4'h0, 12);
      chk("trim item", 32'h2, menu_state);
      op.tap(4'h0, 4'h4);
      repeat (1000) op.tap(4'h0, 4'h1);
      v = $urandom_range(8, 1);
      repeat (v) op.tap(4'h0, 4'h2);
      trim_m = 999 - v;
      op.tap(4'h0, 4'h4);
      chk("return", 32'h0, menu_state);
      chk("trim", trim_m, trim_out);
      chk("phase", trim_m * 64, trim_phase_out);
      rd(4'h2);
      chk("trim reg", trim_m, d);
      op.tap(4'h0, 4'h4);
      chk("reshow", 32'h2, menu_state);
      op.tap(4'h0, 4'h2);
      chk("leave", 32'h0, menu_state);
      op.tap(4'h0, 4'h4);
      chk("reentry", 32'h1, menu_state);
      $display("trim test done");
      repeat (8) begin
         v = $urandom;
         wr(4'h5, v);
         wr(4'h3, v);
         wr(4'h4, v);
         wr(4'h0, v);
         @(posedge clock);
         #1;
         chk("relay", {v[1:0], v[5:4]}, relay_out);
         chk("freewheel", v[7:0], freewheel_out);
         chk("servo", {{28{v[11]}}, v[11:8]}, servo_gain_out);
         chk("ttl", v[1:0], ttl_out);
         chk("legacy", v[0], legacy_sync_emulation);
         chk("ref", v[1], ref_video_sel);
         chk("overlay", !v[1], overlay_video_sel);
         chk("fw trim", trim_m, trim_out);
      end
      rd(4'hf);
      chk("unmapped", 32'h0, d);
      rd(4'h1);
      chk("status", 32'h3, d[4:3]);
      $display("register test done");
      power_on(trim_m);
      conclude();
   end
endmodule : front_panel_setup_ctrl_bench
